//--- hdl/watch_timer_pkg.sv
// Purpose: constants for the watch and interval timer
// Assumes: 32-bit AXI4-Lite register bus, 50 MHz system clock
// Notes: each register owns one word; byte address is four times its index
package watch_timer_pkg;
  localparam logic [15:0] MODE_INDEX      = 16'hff6f;
  localparam logic [15:0] STATUS_INDEX    = 16'hff70;
  localparam logic [15:0] MASK_INDEX      = 16'hff71;
  localparam logic [15:0] BITOP_INDEX     = 16'hff72;
  localparam logic [17:0] MODE_OFFSET     = {MODE_INDEX, 2'b00};
  localparam logic [17:0] STATUS_OFFSET   = {STATUS_INDEX, 2'b00};
  localparam logic [17:0] MASK_OFFSET     = {MASK_INDEX, 2'b00};
  localparam logic [17:0] BITOP_OFFSET    = {BITOP_INDEX, 2'b00};
  localparam int          MODE_LANE       = 0;
  localparam logic [7:0]  MODE_RESET      = 8'h00;
  localparam int          ENABLE_BIT      = 0;
  localparam int          RUN_BIT         = 1;
  localparam int          WPER_LSB        = 2;
  localparam int          IPER_LSB        = 4;
  localparam int          SRC_BIT         = 7;
  localparam int          IRQ_WATCH_BIT   = 0;
  localparam int          IRQ_INTVL_BIT   = 1;
  localparam int          PRESCALER_W     = 11;
  localparam int          COUNTER_W       = 5;
  localparam int          INTVL_BASE_TAP  = 3;
  localparam int          MAIN_DIV        = 128;
  localparam logic [1:0]  AXI_OKAY        = 2'b00;
  localparam logic [1:0]  AXI_SLVERR      = 2'b10;
endpackage : watch_timer_pkg

//--- hdl/watch_and_interval_timer.sv
// Purpose: watch timer with shared prescaler and interval timer
// Assumes: main clock is this system clock, divided here by 128; sub clock is a pin
// Notes:
// Operation
// R1: reset clears mode register to zero, all counting off
// R2: bit 7 picks main clock divided by 128 or subsystem clock
// R3: bits 6..4 pick interval period 2^4 to 2^11 watch clocks
// R4: bits 3..2 pick watch period 2^14, 2^13, 2^5, 2^4
// R5: run bit 1 runs 5-bit counter; 0 stops and clears it
// R6: enable bit 0 stops everything and clears prescaler and counter
// R7: watch counting needs both enable and run bits set
// R8: clearing only run bit clears counter, prescaler keeps counting
// R9: first watch irq after restart may be off by 2^9 clocks
// R10: interval irq repeats whenever enable is set, regardless of run
// R11: after first watch irq, later ones spaced exactly one period
// R12: software keeps bits 7..4 steady while the timer runs
// R13: mode bits writable singly via set/clear or whole byte
// R14: watch and interval functions share prescaler concurrently
// R15: each irq event is a one-cycle pulse on the system clock
// R16: prescaler steps per watch clock; counter steps on selected tap
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module watch_and_interval_timer (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        subClockPin,
  input  wire logic [17:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [17:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             watchPeriodIrq,
  output logic             intervalPeriodIrq,
  output logic             irq
);
  localparam int DIVW = $clog2(watch_timer_pkg::MAIN_DIV);

  logic [7:0]  mode_ff, nxt_mode;
  logic [1:0]  status_ff, nxt_status;
  logic [1:0]  mask_ff, nxt_mask;
  logic        awHeld_ff, nxt_awHeld;
  logic [17:0] awAddr_ff, nxt_awAddr;
  logic        wHeld_ff, nxt_wHeld;
  logic [31:0] wData_ff, nxt_wData;
  logic [3:0]  wStrb_ff, nxt_wStrb;
  logic        bValid_ff, nxt_bValid;
  logic [1:0]  bResp_ff, nxt_bResp;
  logic        rValid_ff, nxt_rValid;
  logic [31:0] rData_ff, nxt_rData;
  logic [1:0]  rResp_ff, nxt_rResp;
  logic [2:0]  subSync_ff, nxt_subSync;
  logic [DIVW-1:0] mainDiv_ff, nxt_mainDiv;
  logic [watch_timer_pkg::PRESCALER_W-1:0] pre_ff, nxt_pre;
  logic [watch_timer_pkg::COUNTER_W-1:0]   cnt_ff, nxt_cnt;
  logic        watchPulse_ff, nxt_watchPulse;
  logic        intvlPulse_ff, nxt_intvlPulse;

  logic        enable, running, watchTick, doWrite;
  logic [watch_timer_pkg::PRESCALER_W-1:0] preInc, carries;
  logic [watch_timer_pkg::PRESCALER_W:0]   preTaps;
  logic        watchTap, intvlTap, cntWrap;

  assign enable  = mode_ff[watch_timer_pkg::ENABLE_BIT];
  assign running = enable & mode_ff[watch_timer_pkg::RUN_BIT]; // R7

  // watch clock tick: main/128 or rising edge of synchronised sub clock
  // sub clock must run slower than a quarter of the system clock
  always_comb begin
    nxt_subSync = {subSync_ff[1:0], subClockPin};
    nxt_mainDiv = mainDiv_ff + 1'b1;
    if (!enable) begin
      nxt_mainDiv = '0;
    end
    if (mode_ff[watch_timer_pkg::SRC_BIT]) begin // R2
      watchTick = subSync_ff[1] & ~subSync_ff[2];
    end else begin
      watchTick = enable & (&mainDiv_ff);
    end
  end

  // per-bit carry of the prescaler; tap k fires when bits below k roll over
  assign preInc = pre_ff + 1'b1;
  assign preTaps[0] = watchTick;
  genvar g;
  generate
    for (g = 0; g < watch_timer_pkg::PRESCALER_W; g++) begin : gTap
      assign carries[g] = pre_ff[g] & preTaps[g];
      assign preTaps[g+1] = carries[g];
    end
  endgenerate

  always_comb begin
    // R3
    intvlTap = preTaps[watch_timer_pkg::INTVL_BASE_TAP + 1
                       + mode_ff[watch_timer_pkg::IPER_LSB +: 3]];
    // R4
    unique case (mode_ff[watch_timer_pkg::WPER_LSB +: 2])
      2'b00:   watchTap = preTaps[watch_timer_pkg::PRESCALER_W - 2];
      2'b01:   watchTap = preTaps[watch_timer_pkg::PRESCALER_W - 3];
      2'b10:   watchTap = preTaps[0];
      2'b11:   watchTap = preTaps[0];
      default: watchTap = 1'b0;
    endcase
  end

  // short periods count straight watch clocks; long ones count 2^9 or 2^8 taps
  assign cntWrap = watchTap &
                   ((mode_ff[watch_timer_pkg::WPER_LSB +: 2] == 2'b11)
                    ? (cnt_ff[3:0] == 4'hf) : (&cnt_ff)); // R16

  always_comb begin
    nxt_pre        = pre_ff;
    nxt_cnt        = cnt_ff;
    nxt_watchPulse = 1'b0;
    nxt_intvlPulse = 1'b0;
    if (!enable) begin // R6
      nxt_pre = '0;
      nxt_cnt = '0;
    end else begin
      if (watchTick) begin
        nxt_pre = preInc; // R16 R14
      end
      nxt_intvlPulse = intvlTap; // R10 R15
      if (!running) begin
        nxt_cnt = '0; // R5 R8 R9
      end else if (watchTap) begin
        nxt_cnt = cntWrap ? '0 : cnt_ff + 1'b1; // R11
        nxt_watchPulse = cntWrap; // R15
      end
    end
  end

  // AXI4-Lite slave; mode also reachable as bit set/clear (R13)
  // each register owns one word, so mode sits in byte lane 0
  assign s_axi_awready = ~awHeld_ff & ~bValid_ff;
  assign s_axi_wready  = ~wHeld_ff & ~bValid_ff;
  assign s_axi_arready = ~rValid_ff;
  assign doWrite = awHeld_ff & wHeld_ff & ~bValid_ff;

  always_comb begin
    nxt_awHeld = awHeld_ff;
    nxt_awAddr = awAddr_ff;
    nxt_wHeld  = wHeld_ff;
    nxt_wData  = wData_ff;
    nxt_wStrb  = wStrb_ff;
    nxt_bValid = bValid_ff;
    nxt_bResp  = bResp_ff;
    nxt_rValid = rValid_ff;
    nxt_rData  = rData_ff;
    nxt_rResp  = rResp_ff;
    nxt_mode   = mode_ff;
    nxt_mask   = mask_ff;
    nxt_status = status_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_awHeld = 1'b1;
      nxt_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_wHeld = 1'b1;
      nxt_wData = s_axi_wdata;
      nxt_wStrb = s_axi_wstrb;
    end
    if (doWrite) begin
      nxt_awHeld = 1'b0;
      nxt_wHeld  = 1'b0;
      nxt_bValid = 1'b1;
      nxt_bResp  = watch_timer_pkg::AXI_OKAY;
      unique case ({awAddr_ff[17:2], 2'b00})
        watch_timer_pkg::MODE_OFFSET: begin
          if (wStrb_ff[watch_timer_pkg::MODE_LANE]) begin
            nxt_mode = wData_ff[7:0]; // R13
          end
        end
        watch_timer_pkg::STATUS_OFFSET: begin
          if (wStrb_ff[0]) begin
            nxt_status = status_ff & ~wData_ff[1:0];
          end
        end
        watch_timer_pkg::MASK_OFFSET: begin
          if (wStrb_ff[0]) begin
            nxt_mask = wData_ff[1:0];
          end
        end
        watch_timer_pkg::BITOP_OFFSET: begin
          // byte0 = bits to set, byte1 = bits to clear
          if (wStrb_ff[0]) begin
            nxt_mode = nxt_mode | wData_ff[7:0]; // R13
          end
          if (wStrb_ff[1]) begin
            nxt_mode = nxt_mode & ~wData_ff[15:8]; // R13
          end
        end
        default: nxt_bResp = watch_timer_pkg::AXI_SLVERR;
      endcase
    end
    if (bValid_ff && s_axi_bready) begin
      nxt_bValid = 1'b0;
    end
    // set wins over a same-cycle clear
    nxt_status[watch_timer_pkg::IRQ_WATCH_BIT] =
      nxt_status[watch_timer_pkg::IRQ_WATCH_BIT] | watchPulse_ff;
    nxt_status[watch_timer_pkg::IRQ_INTVL_BIT] =
      nxt_status[watch_timer_pkg::IRQ_INTVL_BIT] | intvlPulse_ff;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rValid = 1'b1;
      nxt_rResp  = watch_timer_pkg::AXI_OKAY;
      unique case ({s_axi_araddr[17:2], 2'b00})
        watch_timer_pkg::MODE_OFFSET:   nxt_rData = {24'h000000, mode_ff};
        watch_timer_pkg::STATUS_OFFSET: nxt_rData = {30'h0, status_ff};
        watch_timer_pkg::MASK_OFFSET:   nxt_rData = {30'h0, mask_ff};
        watch_timer_pkg::BITOP_OFFSET:  nxt_rData = 32'h00000000;
        default: begin
          nxt_rData = 32'h00000000;
          nxt_rResp = watch_timer_pkg::AXI_SLVERR;
        end
      endcase
    end else if (rValid_ff && s_axi_rready) begin
      nxt_rValid = 1'b0;
    end
  end

  // synchroniser and main-clock divider
  always_ff @(posedge clock) begin
    if (rst) begin
      subSync_ff    <= '0;
      mainDiv_ff    <= '0;
    end else begin
      subSync_ff    <= nxt_subSync;
      mainDiv_ff    <= nxt_mainDiv;
    end
  end

  // prescaler, 5-bit counter and event pulses
  always_ff @(posedge clock) begin
    if (rst) begin
      pre_ff        <= '0;
      cnt_ff        <= '0;
      watchPulse_ff <= 1'b0;
      intvlPulse_ff <= 1'b0;
    end else begin
      pre_ff        <= nxt_pre;
      cnt_ff        <= nxt_cnt;
      watchPulse_ff <= nxt_watchPulse;
      intvlPulse_ff <= nxt_intvlPulse;
    end
  end

  // software-visible registers
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_ff       <= watch_timer_pkg::MODE_RESET; // R1
      status_ff     <= '0;
      mask_ff       <= '0;
    end else begin
      mode_ff       <= nxt_mode;
      status_ff     <= nxt_status;
      mask_ff       <= nxt_mask;
    end
  end

  // bus channel state
  always_ff @(posedge clock) begin
    if (rst) begin
      awHeld_ff     <= 1'b0;
      awAddr_ff     <= '0;
      wHeld_ff      <= 1'b0;
      wData_ff      <= '0;
      wStrb_ff      <= '0;
      bValid_ff     <= 1'b0;
      bResp_ff      <= '0;
      rValid_ff     <= 1'b0;
      rData_ff      <= '0;
      rResp_ff      <= '0;
    end else begin
      awHeld_ff     <= nxt_awHeld;
      awAddr_ff     <= nxt_awAddr;
      wHeld_ff      <= nxt_wHeld;
      wData_ff      <= nxt_wData;
      wStrb_ff      <= nxt_wStrb;
      bValid_ff     <= nxt_bValid;
      bResp_ff      <= nxt_bResp;
      rValid_ff     <= nxt_rValid;
      rData_ff      <= nxt_rData;
      rResp_ff      <= nxt_rResp;
    end
  end

  assign s_axi_bvalid      = bValid_ff;
  assign s_axi_bresp       = bResp_ff;
  assign s_axi_rvalid      = rValid_ff;
  assign s_axi_rdata       = rData_ff;
  assign s_axi_rresp       = rResp_ff;
  assign watchPeriodIrq    = watchPulse_ff;
  assign intervalPeriodIrq = intvlPulse_ff;
  assign irq               = |(status_ff & mask_ff);
endmodule : watch_and_interval_timer
`default_nettype wire

//--- verification/watch_timer_chk.sv
// Purpose: port checks for the watch and interval timer
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module watch_timer_chk (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        watchPeriodIrq,
  input wire logic        intervalPeriodIrq,
  input wire logic        irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_RST_QUIET: assert property (disable iff (1'b0)
    rst |=> !watchPeriodIrq && !intervalPeriodIrq && !irq)
    else $error("outputs active after reset");
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_RD_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_NO_AW: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_NO_AR: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  // no period is shorter than 16 ticks of at least 4 cycles
  AST_W_PULSE: assert property (
    watchPeriodIrq |=> !watchPeriodIrq [*8])
    else $error("watch pulse too long");
  AST_I_PULSE: assert property (
    intervalPeriodIrq |=> !intervalPeriodIrq [*8])
    else $error("interval pulse too long");
  COV_W: cover property (watchPeriodIrq);
  COV_I: cover property (intervalPeriodIrq && !watchPeriodIrq);
  COV_IRQ: cover property (irq);
endmodule : watch_timer_chk
bind watch_and_interval_timer watch_timer_chk CHK (
  .clock(clock),
  .rst(rst),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .watchPeriodIrq(watchPeriodIrq),
  .intervalPeriodIrq(intervalPeriodIrq),
  .irq(irq)
);
`default_nettype wire

//--- verification/watch_and_interval_timer_tb.sv
// Purpose: bus-driven regression of the watch and interval timer
// Assumes: sub clock pin made here at one rising edge per 6 cycles
// Notes: the two slowest watch periods are only written and read back
`timescale 1ns/1ps
`default_nettype none
module watch_and_interval_timer_tb;
  logic        clock = 0, rst = 1, subPin = 0;
  logic [17:0] awAddr = 0, arAddr = 0;
  logic [31:0] wData = 0, rData, d;
  logic [3:0]  wStrb = 0;
  logic        awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  logic        awReady, wReady, bValid, arReady, rValid, wIrq, iIrq, irq;
  logic [1:0]  bResp, rResp, rs, subDiv = 0;
  int          errTotal = 0, nCompared = 0, cyc = 0, pCnt = 0, t0, t1, p;
  int          wCnt = 0, ts;
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    pCnt <= pCnt + int'(wIrq === 1'b1) + int'(iIrq === 1'b1);
    wCnt <= wCnt + int'(wIrq === 1'b1);
    subDiv <= (subDiv == 2'h2) ? 2'h0 : subDiv + 2'h1;
    if (subDiv == 2'h2) subPin <= ~subPin;
  end
  watch_and_interval_timer DUT (
    .clock(clock), .rst(rst), .subClockPin(subPin),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .watchPeriodIrq(wIrq), .intervalPeriodIrq(iIrq), .irq(irq));
  task automatic check(input string nm, input logic [31:0] e, g);
    nCompared++;
    if (g !== e) begin
      errTotal++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // response ready rises only once the answer is seen, so the slave
  // must hold its answer for a cycle
  task automatic wr(input logic [17:0] a, input logic [31:0] v,
                    input logic [3:0] s);
    logic ga, gw, bv, g;
    g = 0;
    @(posedge clock);
    awAddr <= a;
    wData <= v;
    wStrb <= s;
    awValid <= 1'b1;
    wValid <= 1'b1;
    while (!g) begin
      @(negedge clock);
      ga = awValid && awReady;
      gw = wValid && wReady;
      bv = bValid;
      g = bValid && bReady;
      rs = bResp;
      @(posedge clock);
      if (ga) awValid <= 1'b0;
      if (gw) wValid <= 1'b0;
      if (g) bReady <= 1'b0;
      else if (bv) bReady <= 1'b1;
    end
  endtask : wr
  task automatic rd(input logic [17:0] a);
    logic ga, rv, g;
    g = 0;
    @(posedge clock);
    arAddr <= a;
    arValid <= 1'b1;
    while (!g) begin
      @(negedge clock);
      ga = arValid && arReady;
      rv = rValid;
      g = rValid && rReady;
      d = rData;
      rs = rResp;
      @(posedge clock);
      if (ga) arValid <= 1'b0;
      if (g) rReady <= 1'b0;
      else if (rv) rReady <= 1'b1;
    end
  endtask : rd
  // always stop before a new mode so bits 7..4 never change while running
  task automatic md(input logic [7:0] m);
    wr(watch_timer_pkg::MODE_OFFSET, 32'h0, 4'h1);
    wr(watch_timer_pkg::MODE_OFFSET, {24'h0, m}, 4'h1);
  endtask : md
  task automatic pulse(input logic w, output int t);
    t = -1;
    for (int n = 0; n < 20000 && t < 0; n++) begin
      @(negedge clock);
      if ((w ? wIrq : iIrq) === 1'b1) t = cyc;
    end
    if (t < 0) begin
      errTotal++;
      $display("Error %s pulse expected 1 seen 0", w ? "watch" : "interval");
    end
  endtask : pulse
  task automatic per(input logic w, input int e);
    pulse(w, t0);
    pulse(w, t1);
    check(w ? "watch period" : "interval period", e, t1 - t0);
  endtask : per
  task automatic testDone;
    $display("compared %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : testDone
  initial begin
    repeat (90000) @(posedge clock);
    errTotal++;
    testDone;
  end
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(watch_timer_pkg::MODE_OFFSET);
    check("mode reset", 32'h0, d);
    rd(18'h3fc00);
    check("unmapped resp", watch_timer_pkg::AXI_SLVERR, rs);
    check("unmapped data", 32'h0, d);
    wr(18'h3fc00, 32'h1, 4'hf);
    check("unmapped write", watch_timer_pkg::AXI_SLVERR, rs);
    for (int c = 0; c < 4; c++) begin
      md({4'h0, c[1:0], 2'h0});
      rd(watch_timer_pkg::MODE_OFFSET);
      check("mode readback", {28'h0, c[1:0], 2'h0}, d);
    end
    $display("test registers done");
    // run bit left clear: interval still runs
    for (int c = 0; c < 8; c++) begin
      md({1'b1, c[2:0], 4'h1});
      per(0, 6 << (4 + c));
    end
    md(8'h01);
    per(0, 2048);
    $display("test interval done");
    md(8'h9f);
    per(1, 96);
    per(0, 192);
    md(8'h9b);
    per(1, 192);
    $display("test watch done");
    // both periods 2^4 ticks, so a running counter would fire in the window
    md(8'h8f);
    pulse(0, t0);
    wr(watch_timer_pkg::BITOP_OFFSET, 32'h200, 4'h2);
    p = wCnt;
    pulse(0, t1);
    check("restart interval", 96, t1 - t0);
    per(0, 96);
    check("watch halted", p, wCnt);
    wr(watch_timer_pkg::BITOP_OFFSET, 32'h2, 4'h1);
    ts = cyc;
    rd(watch_timer_pkg::MODE_OFFSET);
    check("bit set", 32'h0000_008f, d);
    pulse(1, t0);
    pulse(1, t1);
    p = int'((t0 - ts >= 84) && (t0 - ts <= 102));
    check("restart first", 32'h1, p);
    check("restart period", 96, t1 - t0);
    wr(watch_timer_pkg::BITOP_OFFSET, 32'h100, 4'h2);
    p = pCnt;
    repeat (400) @(posedge clock);
    check("all halted", p, pCnt);
    $display("test restart done");
    rd(watch_timer_pkg::STATUS_OFFSET);
    check("status", 32'h3, d);
    check("irq masked", 1'b0, irq);
    wr(watch_timer_pkg::MASK_OFFSET, 32'h3, 4'h1);
    rd(watch_timer_pkg::STATUS_OFFSET);
    check("irq on", 1'b1, irq);
    wr(watch_timer_pkg::STATUS_OFFSET, 32'h1, 4'h1);
    rd(watch_timer_pkg::STATUS_OFFSET);
    check("status clear", 32'h2, d);
    wr(watch_timer_pkg::STATUS_OFFSET, 32'h2, 4'h1);
    rd(watch_timer_pkg::STATUS_OFFSET);
    check("irq off", 1'b0, irq);
    $display("test interrupt done");
    testDone;
  end
endmodule : watch_and_interval_timer_tb
`default_nettype wire
